/* File: logic/anp_params.svh */
// offsets, field positions, reset values for the negotiation result registers
// assumes inclusion by the register bank and its package only
`ifndef ANP_PARAMS_SVH
`define ANP_PARAMS_SVH

`define ANP_OFS_ABILITY     5'h05
`define ANP_OFS_EXPANSION   5'h06
`define ANP_OFS_XPAGE_TX    5'h07

// partner ability fields
`define ANP_AB_NEXT_PAGE    15
`define ANP_AB_ACK          14
`define ANP_AB_FAR_FAULT    13
`define ANP_AB_RSVD         12
`define ANP_AB_ASYM_PAUSE   11
`define ANP_AB_PAUSE        10
`define ANP_AB_TECH_HI      9
`define ANP_AB_TECH_LO      5
`define ANP_AB_SEL_HI       4
`define ANP_AB_SEL_LO       0
`define ANP_AB_RESET        16'h0000

// expansion fields
`define ANP_EX_LOC_KNOWN    6
`define ANP_EX_STORE_PLACE  5
`define ANP_EX_PD_FAULT     4
`define ANP_EX_LP_XPAGE     3
`define ANP_EX_LOC_XPAGE    2
`define ANP_EX_PAGE_RX      1
`define ANP_EX_LP_AN        0

// extra page transmit fields
`define ANP_TX_NEXT_PAGE    15
`define ANP_TX_ACK          14
`define ANP_TX_MSG_PAGE     13
`define ANP_TX_COMPLY       12
`define ANP_TX_ALT          11
`define ANP_TX_CODE_HI      10
`define ANP_TX_CODE_LO      0
`define ANP_TX_NP_RESET     1'b0
`define ANP_TX_MP_RESET     1'b1
`define ANP_TX_CPL_RESET    1'b0
`define ANP_TX_ALT_RESET    1'b0
`define ANP_TX_CODE_RESET   11'h001

`endif

/* File: logic/anp_pkg.sv */
// types shared by the negotiation result register bank
// assumes anp_params.svh is on the include path
package anp_pkg;
   `include "anp_params.svh"

   typedef logic [4:0]  anp_addr_t;
   typedef logic [15:0] anp_word_t;

   typedef enum logic [1:0] {
      ANP_SEL_NONE,
      ANP_SEL_ABILITY,
      ANP_SEL_EXPANSION,
      ANP_SEL_XPAGE_TX
   } anp_sel_t;
endpackage

/* File: logic/anp_regs.sv */
// negotiation result bank: partner ability, expansion and extra page transmit
// assumes the negotiation engine runs on mclk and drives its event strobes
// as one-cycle pulses; register port is a plain strobe bus with read data
// one cycle after the read strobe
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "anp_params.svh"

module anp_regs #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 5
) (
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // register port
   input  wire anp_pkg::anp_addr_t reg_addr,
   input  wire anp_pkg::anp_word_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output anp_pkg::anp_word_t     reg_rdata,
   // negotiation engine, same clock
   input  wire logic              page_rx_stb,
   input  wire logic              page_rx_base,
   input  wire anp_pkg::anp_word_t page_rx_word,
   input  wire logic              burst_ack_stb,
   input  wire logic              burst_ack_val,
   input  wire logic              an_complete,
   input  wire logic              pd_fault_stb,
   input  wire logic              partner_negotiation_capable,
   input  wire logic              local_ack,
   input  wire logic              page_tx_stb,
   input  wire logic              page_tx_toggle,
   // page handed to the transmitter
   output anp_pkg::anp_word_t     xpage_word,
   output logic                   xpage_request
);
   import anp_pkg::*;

   // the field map is fixed: 16-bit words, 5-bit register index
   if (DATA_W != 16) begin : g_bad_data_w
      $error("anp_regs: DATA_W must be 16");
   end
   if (ADDR_W != 5) begin : g_bad_addr_w
      $error("anp_regs: ADDR_W must be 5");
   end
   // every field position must land inside the word
   if (`ANP_AB_NEXT_PAGE >= DATA_W || `ANP_TX_NEXT_PAGE >= DATA_W) begin : g_bad_field
      $error("anp_regs: field position beyond word width");
   end
   // reset constants must be exactly as wide as their fields
   if ($bits(`ANP_AB_RESET) != DATA_W) begin : g_bad_ab_reset
      $error("anp_regs: ability reset value width mismatch");
   end
   if ($bits(`ANP_TX_CODE_RESET) != `ANP_TX_CODE_HI - `ANP_TX_CODE_LO + 1) begin : g_bad_code
      $error("anp_regs: code reset value width mismatch");
   end

   localparam logic [4:0] TECH_W = 5'(`ANP_AB_TECH_HI - `ANP_AB_TECH_LO + 1);

   // technology abilities, one bit per ability, wire order kept
   logic [TECH_W-1:0] tech_rx;
   for (genvar gi = 0; gi < TECH_W; gi++) begin : g_tech
      assign tech_rx[gi] = page_rx_word[`ANP_AB_TECH_LO + gi];
   end

   // selector bits taken as sent; no decoding of the protocol here
   logic [`ANP_AB_SEL_HI-`ANP_AB_SEL_LO:0] selector_rx;
   for (genvar gs = 0; gs <= `ANP_AB_SEL_HI - `ANP_AB_SEL_LO; gs++) begin : g_sel
      assign selector_rx[gs] = page_rx_word[`ANP_AB_SEL_LO + gs];
   end

   // partner ability state
   anp_word_t  partner_ability_q;
   anp_word_t  partner_ability_d;

   // expansion state
   logic       parallel_detect_fault_q;
   logic       parallel_detect_fault_d;
   logic       partner_extra_page_capable_q;
   logic       partner_extra_page_capable_d;
   logic       page_rx_q;
   logic       page_rx_d;
   logic       partner_an_q;
   logic       partner_an_d;

   // extra page transmit state
   logic        next_page_flag_q;
   logic        next_page_flag_d;
   logic        message_page_flag_q;
   logic        message_page_flag_d;
   logic        comply_confirm_bit_q;
   logic        comply_confirm_bit_d;
   logic        alternation_bit_q;
   logic        alternation_bit_d;
   logic        local_ack_q;
   logic        local_ack_d;
   logic [10:0] code_q;
   logic [10:0] code_d;

   // bus outputs
   anp_word_t  rdata_q;
   anp_word_t  rdata_d;
   anp_word_t  xword_q;
   anp_word_t  xword_d;
   logic       xreq_q;
   logic       xreq_d;

   anp_sel_t   sel;
   anp_word_t  expansion_view;
   anp_word_t  xpage_view;
   logic       capture_base;

   // address decode
   // unmapped indices read zero and swallow writes
   always_comb begin
      unique case (reg_addr)
         `ANP_OFS_ABILITY:   sel = ANP_SEL_ABILITY;
         `ANP_OFS_EXPANSION: sel = ANP_SEL_EXPANSION;
         `ANP_OFS_XPAGE_TX:  sel = ANP_SEL_XPAGE_TX;
         default:            sel = ANP_SEL_NONE;
      endcase
   end

   // partner ability: base pages only; extra pages never land here
   always_comb begin
      // local device is always extra page able, so the post-completion
      // rewrite is allowed; kept explicit in case that constant changes
      capture_base = page_rx_stb && page_rx_base;
      if (an_complete && !local_extra_page_capable()) begin
         capture_base = 1'b0;
      end
      partner_ability_d = partner_ability_q;
      if (capture_base) begin
         partner_ability_d[`ANP_AB_NEXT_PAGE] =
            page_rx_word[`ANP_AB_NEXT_PAGE];
         partner_ability_d[`ANP_AB_ACK] = page_rx_word[`ANP_AB_ACK];
         partner_ability_d[`ANP_AB_FAR_FAULT] =
            page_rx_word[`ANP_AB_FAR_FAULT];
         partner_ability_d[`ANP_AB_ASYM_PAUSE] =
            page_rx_word[`ANP_AB_ASYM_PAUSE];
         partner_ability_d[`ANP_AB_PAUSE] =
            page_rx_word[`ANP_AB_PAUSE];
         partner_ability_d[`ANP_AB_TECH_HI:`ANP_AB_TECH_LO] = tech_rx;
         partner_ability_d[`ANP_AB_SEL_HI:`ANP_AB_SEL_LO]   = selector_rx;
      end
      // acknowledge follows every burst, later than the page capture
      if (burst_ack_stb) begin
         partner_ability_d[`ANP_AB_ACK] = burst_ack_val;
      end
      // reserved bit never takes a value from the wire
      partner_ability_d[`ANP_AB_RSVD] = 1'b0;
   end

   function automatic logic local_extra_page_capable();
      return 1'b1;
   endfunction

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         partner_ability_q <= `ANP_AB_RESET;
      end else begin
         partner_ability_q <= partner_ability_d;
      end
   end

   // expansion status; read of this register clears the latched flags,
   // but an event in the same cycle wins so it is never lost
   always_comb begin
      logic rd_exp;
      rd_exp = reg_rd && (sel == ANP_SEL_EXPANSION);

      page_rx_d = page_rx_q;
      if (rd_exp) begin
         page_rx_d = 1'b0;
      end
      if (page_rx_stb) begin
         page_rx_d = 1'b1;
      end

      parallel_detect_fault_d = parallel_detect_fault_q;
      if (rd_exp) begin
         parallel_detect_fault_d = 1'b0;
      end
      if (pd_fault_stb) begin
         parallel_detect_fault_d = 1'b1;
      end

      partner_extra_page_capable_d = partner_extra_page_capable_q;
      if (page_rx_stb && page_rx_base) begin
         partner_extra_page_capable_d =
            page_rx_word[`ANP_AB_NEXT_PAGE];
      end

      partner_an_d = partner_negotiation_capable;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         page_rx_q                    <= 1'b0;
         parallel_detect_fault_q      <= 1'b0;
         partner_extra_page_capable_q <= 1'b0;
         partner_an_q                 <= 1'b0;
      end else begin
         page_rx_q                    <= page_rx_d;
         parallel_detect_fault_q      <= parallel_detect_fault_d;
         partner_extra_page_capable_q <= partner_extra_page_capable_d;
         partner_an_q                 <= partner_an_d;
      end
   end

   always_comb begin
      // bits 6, 5 and 2 are fixed, so they need no flop
      expansion_view = 16'h0000;
      expansion_view[`ANP_EX_LOC_KNOWN]   = 1'b1;
      expansion_view[`ANP_EX_STORE_PLACE] = 1'b1;
      expansion_view[`ANP_EX_PD_FAULT]    = parallel_detect_fault_q;
      expansion_view[`ANP_EX_LP_XPAGE]    = partner_extra_page_capable_q;
      expansion_view[`ANP_EX_LOC_XPAGE]   = local_extra_page_capable();
      expansion_view[`ANP_EX_PAGE_RX]     = page_rx_q;
      expansion_view[`ANP_EX_LP_AN]       = partner_an_q;
   end

   // extra page transmit: software owns request, message, comply, code;
   // hardware owns acknowledge and alternation
   always_comb begin
      logic wr_tx;
      wr_tx = reg_wr && (sel == ANP_SEL_XPAGE_TX);

      next_page_flag_d     = next_page_flag_q;
      message_page_flag_d  = message_page_flag_q;
      comply_confirm_bit_d = comply_confirm_bit_q;
      code_d               = code_q;
      if (wr_tx) begin
         next_page_flag_d     = reg_wdata[`ANP_TX_NEXT_PAGE];
         message_page_flag_d  = reg_wdata[`ANP_TX_MSG_PAGE];
         comply_confirm_bit_d = reg_wdata[`ANP_TX_COMPLY];
         code_d = reg_wdata[`ANP_TX_CODE_HI:`ANP_TX_CODE_LO];
      end

      local_ack_d = local_ack;

      alternation_bit_d = alternation_bit_q;
      if (page_tx_stb) begin
         alternation_bit_d = ~page_tx_toggle;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         next_page_flag_q     <= `ANP_TX_NP_RESET;
         message_page_flag_q  <= `ANP_TX_MP_RESET;
         comply_confirm_bit_q <= `ANP_TX_CPL_RESET;
         alternation_bit_q    <= `ANP_TX_ALT_RESET;
         local_ack_q          <= 1'b0;
         code_q               <= `ANP_TX_CODE_RESET;
      end else begin
         next_page_flag_q     <= next_page_flag_d;
         message_page_flag_q  <= message_page_flag_d;
         comply_confirm_bit_q <= comply_confirm_bit_d;
         alternation_bit_q    <= alternation_bit_d;
         local_ack_q          <= local_ack_d;
         code_q               <= code_d;
      end
   end

   always_comb begin
      xpage_view = {next_page_flag_q,
                    local_ack_q,
                    message_page_flag_q,
                    comply_confirm_bit_q,
                    alternation_bit_q,
                    code_q};
   end

   // read port and transmit word; ability and expansion take no writes
   // read data drops to zero after its one cycle, so no stale word lingers
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         unique case (sel)
            ANP_SEL_ABILITY:   rdata_d = partner_ability_q;
            ANP_SEL_EXPANSION: rdata_d = expansion_view;
            ANP_SEL_XPAGE_TX:  rdata_d = xpage_view;
            ANP_SEL_NONE:      rdata_d = 16'h0000;
         endcase
      end
      // word follows the next cycle's state so software writes reach the
      // transmitter one cycle after the write strobe
      xword_d = {next_page_flag_d,
                 local_ack_d,
                 message_page_flag_d,
                 comply_confirm_bit_d,
                 alternation_bit_d,
                 code_d};
      xreq_d = next_page_flag_d;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata_q <= 16'h0000;
         // must match the register's reset view, bit for bit
         xword_q <= {`ANP_TX_NP_RESET, 1'b0, `ANP_TX_MP_RESET,
                     `ANP_TX_CPL_RESET, `ANP_TX_ALT_RESET,
                     `ANP_TX_CODE_RESET};
         xreq_q  <= `ANP_TX_NP_RESET;
      end else begin
         rdata_q <= rdata_d;
         xword_q <= xword_d;
         xreq_q  <= xreq_d;
      end
   end

   assign reg_rdata     = rdata_q;
   assign xpage_word    = xword_q;
   assign xpage_request = xreq_q;

   // TECH_W documents the width of the technology group
   if (TECH_W != 5'd5) begin : g_bad_tech_w
      $error("anp_regs: technology field width mismatch");
   end
endmodule

/* File: sim/anp_link_partner.sv */
// remote link partner: hands received pages and burst acks to the bank
// assumes it shares mclk with the bank and is driven by testbench calls
`timescale 1ns/100ps
module anp_link_partner (
   input  wire logic          mclk,
   output logic               page_rx_stb,
   output logic               page_rx_base,
   output anp_pkg::anp_word_t page_rx_word,
   output logic               burst_ack_stb,
   output logic               burst_ack_val,
   output logic               partner_negotiation_capable
);
   import anp_pkg::*;
   initial begin
      page_rx_stb = 1'b0;
      page_rx_base = 1'b0;
      page_rx_word = 16'h0000;
      burst_ack_stb = 1'b0;
      burst_ack_val = 1'b0;
      partner_negotiation_capable = 1'b0;
   end
   // gap gives a slow partner; word is scrambled once no longer valid
   task automatic send_page(input logic base, input anp_word_t w, input int gap);
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      partner_negotiation_capable <= 1'b1;
      page_rx_stb <= 1'b1;
      page_rx_base <= base;
      page_rx_word <= w;
      @(posedge mclk);
      page_rx_stb <= 1'b0;
      page_rx_base <= ~base;
      page_rx_word <= ~w;
   endtask
   task automatic send_ack(input logic v);
      @(posedge mclk);
      burst_ack_stb <= 1'b1;
      burst_ack_val <= v;
      @(posedge mclk);
      burst_ack_stb <= 1'b0;
      burst_ack_val <= ~v;
   endtask
endmodule

/* File: sim/anp_regs_checker.sv */
// concurrent checks on the negotiation result bank, top ports only
// assumes one clock, synchronous reset and one-cycle engine pulses
`timescale 1ns/100ps
module anp_regs_checker (
   input wire logic               mclk,
   input wire logic               sys_rst,
   input wire anp_pkg::anp_addr_t reg_addr,
   input wire anp_pkg::anp_word_t reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire anp_pkg::anp_word_t reg_rdata,
   input wire logic               page_rx_stb,
   input wire logic               page_rx_base,
   input wire anp_pkg::anp_word_t page_rx_word,
   input wire logic               burst_ack_stb,
   input wire logic               burst_ack_val,
   input wire logic               page_tx_stb,
   input wire logic               page_tx_toggle,
   input wire anp_pkg::anp_word_t xpage_word,
   input wire logic               xpage_request
);
   import anp_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_rd5;
      reg_rd && reg_addr == 5'h05 && !page_rx_stb && !burst_ack_stb;
   endsequence
   property p_exp_const;
      $past(reg_rd) && $past(reg_addr) == 5'h06 |-> reg_rdata[15:5] == 11'h003 && reg_rdata[2];
   endproperty
   // the bench reads the ability word first, so the expansion read comes later
   property p_rx_set;
      page_rx_stb ##1 (!(reg_rd && reg_addr == 5'h06))[*3]
         ##1 (reg_rd && reg_addr == 5'h06) |=> reg_rdata[1];
   endproperty
   // idle cycle between reads keeps the clear edge unambiguous
   property p_rx_clr;
      (reg_rd && reg_addr == 5'h06 && !page_rx_stb) ##1 !page_rx_stb
         ##1 (reg_rd && reg_addr == 5'h06 && !page_rx_stb) |=> !reg_rdata[1];
   endproperty
   property p_base_cap;
      (page_rx_stb && page_rx_base && !burst_ack_stb) ##1 (!page_rx_stb && !burst_ack_stb)
         ##1 s_rd5 |=> reg_rdata == ($past(page_rx_word, 3) & 16'hefff);
   endproperty
   property p_ack;
      (burst_ack_stb && !page_rx_stb) ##1 (!page_rx_stb && !burst_ack_stb)
         ##1 s_rd5 |=> reg_rdata[14] == $past(burst_ack_val, 3);
   endproperty
   property p_tog;
      page_tx_stb |=> xpage_word[11] == !$past(page_tx_toggle);
   endproperty
   property p_wr7;
      reg_wr && reg_addr == 5'h07 |=> (xpage_word & 16'hb7ff) == ($past(reg_wdata) & 16'hb7ff);
   endproperty
   property p_ro7;
      reg_wr && reg_addr == 5'h07 && !page_tx_stb |=> $stable(xpage_word[11]);
   endproperty
   property p_np;
      xpage_request == xpage_word[15];
   endproperty

   a_exp_const: assert property (p_exp_const) else $error("expansion constants wrong");
   a_rx_set: assert property (p_rx_set) else $error("page flag not set");
   a_rx_clr: assert property (p_rx_clr) else $error("page flag not cleared by read");
   a_base_cap: assert property (p_base_cap) else $error("base page not captured");
   a_ack: assert property (p_ack) else $error("burst ack not reflected");
   a_tog: assert property (p_tog) else $error("toggle not inverted");
   a_wr7: assert property (p_wr7) else $error("transmit page write lost");
   a_ro7: assert property (p_ro7) else $error("toggle bit writable");
   a_np: assert property (p_np) else $error("request differs from page bit");

   c_base: cover property (page_rx_stb && page_rx_base);
   c_ack: cover property (burst_ack_stb && burst_ack_val);
   c_wr7: cover property (reg_wr && reg_addr == 5'h07);
endmodule

bind anp_regs anp_regs_checker u_chk (
   .mclk           (mclk),
   .sys_rst        (sys_rst),
   .reg_addr       (reg_addr),
   .reg_wdata      (reg_wdata),
   .reg_wr         (reg_wr),
   .reg_rd         (reg_rd),
   .reg_rdata      (reg_rdata),
   .page_rx_stb    (page_rx_stb),
   .page_rx_base   (page_rx_base),
   .page_rx_word   (page_rx_word),
   .burst_ack_stb  (burst_ack_stb),
   .burst_ack_val  (burst_ack_val),
   .page_tx_stb    (page_tx_stb),
   .page_tx_toggle (page_tx_toggle),
   .xpage_word     (xpage_word),
   .xpage_request  (xpage_request)
);

/* File: sim/testbench.sv */
// self-checking bench for the negotiation result bank
// assumes strobe register bus, read data one cycle after the read strobe
`timescale 1ns/100ps
module testbench;
   import anp_pkg::*;
   logic      mclk = 1'b0;
   logic      sys_rst = 1'b1;
   anp_addr_t reg_addr = 5'h00;
   anp_word_t reg_wdata = 16'h0000;
   logic      reg_wr = 1'b0, reg_rd = 1'b0, an_complete = 1'b0, pd_fault_stb = 1'b0;
   logic      local_ack = 1'b0, page_tx_stb = 1'b0, page_tx_toggle = 1'b0;
   anp_word_t reg_rdata, xpage_word, page_rx_word;
   logic      xpage_request, page_rx_stb, page_rx_base, burst_ack_stb, burst_ack_val, lp_an;
   int        error_cnt = 0, total_checks = 0;
   anp_word_t tx_tab[4] = '{16'h0000, 16'h2001, 16'h1123, 16'h97ff};
   anp_word_t pg_tab[6] = '{16'h8001, 16'h2020, 16'h0c00, 16'h03e1, 16'h5555, 16'hffff};

   always #5 mclk = ~mclk;

   anp_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .page_rx_stb(page_rx_stb),
      .page_rx_base(page_rx_base), .page_rx_word(page_rx_word), .burst_ack_stb(burst_ack_stb),
      .burst_ack_val(burst_ack_val), .an_complete(an_complete), .pd_fault_stb(pd_fault_stb),
      .partner_negotiation_capable(lp_an), .local_ack(local_ack), .page_tx_stb(page_tx_stb),
      .page_tx_toggle(page_tx_toggle), .xpage_word(xpage_word), .xpage_request(xpage_request));
   anp_link_partner u_lp (.mclk(mclk), .page_rx_stb(page_rx_stb), .page_rx_base(page_rx_base),
      .page_rx_word(page_rx_word), .burst_ack_stb(burst_ack_stb),
      .burst_ack_val(burst_ack_val), .partner_negotiation_capable(lp_an));

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input anp_word_t e, input anp_word_t g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input anp_addr_t a, input anp_word_t d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input anp_addr_t a, input anp_word_t e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg %0h", a), e, reg_rdata);
   endtask
   task automatic tx_page(input logic t);
      @(posedge mclk);
      page_tx_stb <= 1'b1;
      page_tx_toggle <= t;
      @(posedge mclk);
      page_tx_stb <= 1'b0;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      chk("xpage_word", 16'h2001, xpage_word);
      chk("xpage_request", 16'h0000, {15'h0000, xpage_request});
      rd(5'h05, 16'h0000);
      rd(5'h06, 16'h0064);
      rd(5'h07, 16'h2001);
      rd(5'h03, 16'h0000);
      wr(5'h05, 16'hffff);
      wr(5'h06, 16'hffff);
      wr(5'h07, 16'hffff);
      wr(5'h1f, 16'hffff);
      rd(5'h05, 16'h0000);
      rd(5'h06, 16'h0064);
      rd(5'h07, 16'hb7ff);
      chk("xpage_request", 16'h0001, {15'h0000, xpage_request});
      $display("test reset and read-only done");
      foreach (tx_tab[i]) begin
         wr(5'h07, tx_tab[i]);
         rd(5'h07, tx_tab[i] & 16'hb7ff);
         chk("xpage_word", tx_tab[i] & 16'hb7ff, xpage_word);
      end
      local_ack <= 1'b1;
      tx_page(1'b0);
      rd(5'h07, 16'hdfff);
      tx_page(1'b1);
      rd(5'h07, 16'hd7ff);
      wr(5'h07, 16'h0000);
      rd(5'h07, 16'h4000);
      $display("test transmit page done");
      foreach (pg_tab[i]) begin
         if (i == 3)
            an_complete <= 1'b1;
         u_lp.send_page(1'b1, pg_tab[i], i);
         rd(5'h05, pg_tab[i] & 16'hefff);
         rd(5'h06, 16'h0067 | {12'h000, pg_tab[i][15], 3'b000});
         rd(5'h06, 16'h0065 | {12'h000, pg_tab[i][15], 3'b000});
      end
      u_lp.send_ack(1'b0);
      rd(5'h05, 16'hafff);
      u_lp.send_ack(1'b1);
      rd(5'h05, 16'hefff);
      u_lp.send_page(1'b0, 16'h9234, 0);
      rd(5'h05, 16'hefff);
      rd(5'h06, 16'h006f);
      @(posedge mclk);
      pd_fault_stb <= 1'b1;
      @(posedge mclk);
      pd_fault_stb <= 1'b0;
      rd(5'h06, 16'h007d);
      rd(5'h06, 16'h006d);
      $display("test partner pages done");
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(5'h05, 16'h0000);
      rd(5'h06, 16'h0065);
      rd(5'h07, 16'h6001);
      $display("test second reset done");
      print_verdict();
   end
endmodule
